// ===== rtl/tcb_timer.sv
// Timer counter base: counter, limits, double buffers and events
`timescale 1ns/1ps
module tcb_timer #(
    parameter int NUM_CH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    input wire logic presc_tick,
    input wire logic count_evt,
    input wire logic [3:0] capt_evt,
    output tcb_pkg::tcb_evt_s evt_q,
    output tcb_pkg::tcb_lim_s lim_q
);
    // ==========================================================
    // Bus slave
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic rd_en;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    logic wr_err;

    tcb_axil u_axil (
        .clk(clk),
        .rst_n(rst_n),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err),
        .wr_err(wr_err)
    );

    // Byte-lane merge for 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // ==========================================================
    // Registers
    logic [31:0] ctrl_q;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [15:0] per_q;
    logic [15:0] perbuf_q;
    logic per_bv_q;
    logic [15:0] cc_q [4];
    logic [15:0] ccbuf_q [4];
    logic [3:0] cc_bv_q;
    logic [3:0] cc_if_q;
    logic ovf_if_q;
    logic err_if_q;

    wire [2:0] clk_sel = ctrl_q[tcb_pkg::CTRL_CLK_LSB +: 3];
    wire dir_down = ctrl_q[tcb_pkg::CTRL_DIR_BIT];
    wire [1:0] wgm = ctrl_q[tcb_pkg::CTRL_WGM_LSB +: 2];
    wire cap_mode = ctrl_q[tcb_pkg::CTRL_CAP_BIT];
    wire [3:0] ch_en = ctrl_q[tcb_pkg::CTRL_CEN_LSB +: 4];
    wire [3:0] ch_mask = (NUM_CH >= 4) ? 4'hf : 4'h3;

    // Write strobes by address
    wire wr_ctrl = wr_en && (wr_addr == tcb_pkg::OFF_CTRL);
    wire wr_count = wr_en && (wr_addr == tcb_pkg::OFF_COUNT);
    wire wr_per = wr_en && (wr_addr == tcb_pkg::OFF_PER);
    wire wr_perbuf = wr_en && (wr_addr == tcb_pkg::OFF_PERBUF);
    wire wr_flags = wr_en && (wr_addr == tcb_pkg::OFF_FLAGS);
    wire wr_ch_any = wr_en && (wr_addr[7:4] == tcb_pkg::OFF_CH_BASE[7:4]);
    wire wr_chb_any = wr_en && (wr_addr[7:4] == tcb_pkg::OFF_CHBUF_BASE[7:4]);
    wire [1:0] wr_idx = wr_addr[3:2];
    wire [1:0] rd_idx = rd_addr[3:2];
    wire rd_ch = rd_addr[7:4] == tcb_pkg::OFF_CH_BASE[7:4];
    wire rd_chb = rd_addr[7:4] == tcb_pkg::OFF_CHBUF_BASE[7:4];
    wire wr_known = wr_ctrl | wr_count | wr_per | wr_perbuf | wr_flags
                    | ((wr_ch_any | wr_chb_any) & ch_mask[wr_idx]);
    assign wr_err = wr_en & ~wr_known & (wr_addr[1:0] == 2'b00)
                    | wr_en & ~wr_known;

    // ==========================================================
    // Counter clocking and limit conditions
    wire tick = (clk_sel == tcb_pkg::TCB_CLK_DIV1) |
                ((clk_sel == tcb_pkg::TCB_CLK_PRE) & presc_tick) |
                ((clk_sel == tcb_pkg::TCB_CLK_EVT) & count_evt);
    wire top_is_cca = (wgm == tcb_pkg::TCB_WG_FREQ);
    wire [15:0] top_val = top_is_cca ? cc_q[0] : per_q;
    wire at_top = count_q == top_val;
    wire at_bottom = count_q == tcb_pkg::RST_VAL16;
    wire at_max = count_q == tcb_pkg::ALL_ONES16;
    wire dual = (wgm == tcb_pkg::TCB_WG_DS);
    wire lim_hit = dir_down ? at_bottom : at_top;
    wire update = tick & (dual ? at_bottom : lim_hit);
    wire ovf_evt = tick & lim_hit;

    // Next counter value: write beats counting
    always_comb begin
        count_d = count_q;
        if (wr_count) begin
            count_d = merge16(count_q, wr_data, wr_strb);
        end else if (tick) begin
            if (!dir_down) begin
                count_d = at_top ? tcb_pkg::RST_VAL16 : count_q + 16'h0001;
            end else begin
                count_d = at_bottom ? per_q : count_q - 16'h0001;
            end
        end
    end

    // Compare matches and captures per channel
    logic [3:0] cmp_hit;
    logic [3:0] cap_hit;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            cmp_hit[i] = ~cap_mode & ch_mask[i] & tick & (count_q == cc_q[i]);
            cap_hit[i] = cap_mode & ch_mask[i] & ch_en[i] & capt_evt[i];
        end
    end
    wire [3:0] cap_over = cap_hit & cc_bv_q & cc_if_q;
    wire err_evt = |cap_over;

    // ==========================================================
    // Control and counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= tcb_pkg::RST_CTRL;
            count_q <= tcb_pkg::RST_VAL16;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= wr_data;
            end
            count_q <= count_d;
        end
    end

    // Period double buffer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            per_q <= tcb_pkg::RST_VAL16;
            perbuf_q <= tcb_pkg::RST_VAL16;
            per_bv_q <= 1'b0;
        end else begin
            if (wr_per) begin
                per_q <= merge16(per_q, wr_data, wr_strb);
            end else if (update && per_bv_q) begin
                per_q <= perbuf_q;
            end
            if (wr_perbuf) begin
                perbuf_q <= merge16(perbuf_q, wr_data, wr_strb);
                per_bv_q <= 1'b1;
            end else if (update) begin
                per_bv_q <= 1'b0;
            end
        end
    end

    // Channel buffers, compare or capture
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                cc_q[i] <= tcb_pkg::RST_VAL16;
                ccbuf_q[i] <= tcb_pkg::RST_VAL16;
            end
            cc_bv_q <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (ch_mask[i]) begin
                    if (wr_ch_any && wr_idx == 2'(i)) begin
                        cc_q[i] <= merge16(cc_q[i], wr_data, wr_strb);
                    end else if (!cap_mode && update && cc_bv_q[i]) begin
                        cc_q[i] <= ccbuf_q[i];
                    end else if (cap_mode && cap_hit[i] && !cc_if_q[i]) begin
                        cc_q[i] <= count_q;
                    end else if (cap_mode && cc_bv_q[i] && !cc_if_q[i]) begin
                        cc_q[i] <= ccbuf_q[i];
                    end
                    if (wr_chb_any && wr_idx == 2'(i)) begin
                        ccbuf_q[i] <= merge16(ccbuf_q[i], wr_data, wr_strb);
                        cc_bv_q[i] <= 1'b1;
                    end else if (cap_mode && cap_hit[i] && cc_if_q[i]) begin
                        ccbuf_q[i] <= count_q;
                        cc_bv_q[i] <= 1'b1;
                    end else if (cap_mode && cc_bv_q[i] && !cc_if_q[i]) begin
                        cc_bv_q[i] <= 1'b0;
                    end else if (!cap_mode && update) begin
                        cc_bv_q[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // Sticky flags, set wins over write-one-to-clear
    wire [3:0] cc_set = (cmp_hit | cap_hit | (cap_mode ? cc_bv_q & ~cc_if_q : 4'h0)) & ch_mask;
    wire [3:0] clr_bits = wr_flags ? wr_data[3:0] : 4'h0;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cc_if_q <= 4'h0;
            ovf_if_q <= 1'b0;
            err_if_q <= 1'b0;
        end else begin
            cc_if_q <= (cc_if_q & ~clr_bits) | cc_set;
            ovf_if_q <= (ovf_if_q & ~(wr_flags & wr_data[4])) | ovf_evt;
            err_if_q <= (err_if_q & ~(wr_flags & wr_data[5])) | err_evt;
        end
    end

    // Event pulses and limit flags, registered one cycle after their conditions
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_q <= '0;
            lim_q <= '0;
        end else begin
            evt_q.ovf <= ovf_evt;
            evt_q.err <= err_evt;
            evt_q.cc <= (cmp_hit | cap_hit) & ch_mask;
            lim_q.bottom <= at_bottom;
            lim_q.max <= at_max;
            lim_q.top <= at_top;
            lim_q.update <= update;
        end
    end

    // ==========================================================
    // Read mux
    wire [31:0] status_w = {26'h0, per_bv_q, cc_bv_q & ch_mask, at_bottom};
    wire [31:0] flags_w = {26'h0, err_if_q, ovf_if_q, cc_if_q};
    wire rd_known = (rd_addr == tcb_pkg::OFF_CTRL) | (rd_addr == tcb_pkg::OFF_STATUS)
                    | (rd_addr == tcb_pkg::OFF_COUNT) | (rd_addr == tcb_pkg::OFF_PER)
                    | (rd_addr == tcb_pkg::OFF_PERBUF) | (rd_addr == tcb_pkg::OFF_FLAGS)
                    | ((rd_ch | rd_chb) & ch_mask[rd_idx]);
    assign rd_err = rd_en & ~rd_known;
    assign rd_data = (rd_addr == tcb_pkg::OFF_CTRL) ? ctrl_q :
                     (rd_addr == tcb_pkg::OFF_STATUS) ? status_w :
                     (rd_addr == tcb_pkg::OFF_COUNT) ? {16'h0, count_q} :
                     (rd_addr == tcb_pkg::OFF_PER) ? {16'h0, per_q} :
                     (rd_addr == tcb_pkg::OFF_PERBUF) ? {16'h0, perbuf_q} :
                     (rd_addr == tcb_pkg::OFF_FLAGS) ? flags_w :
                     (rd_ch && ch_mask[rd_idx]) ? {16'h0, cc_q[rd_idx]} :
                     (rd_chb && ch_mask[rd_idx]) ? {16'h0, ccbuf_q[rd_idx]} :
                     32'h0000_0000;
endmodule : tcb_timer

// ===== rtl/tcb_pkg.sv
// Package of constants and types for the timer counter base block
// Operation
// - Counter, period and channel values are all sixteen bits wide.
// - Up to four channels exist; the reduced variant keeps state for two only.
// - Channels are either all compare channels or all capture channels.
// - Bottom is flagged when the counter becomes zero.
// - Maximum is flagged when the counter becomes all ones.
// - Top is the period or channel A compare value, chosen by the waveform mode.
// - Update fires at bottom in the TCB_WG_DS mode, else at top or bottom by the count direction.
// - Period and every channel value sit behind a separately writable buffer.
// - Overflow, error and one event per channel are produced.
// - The counter counts clocks or events, with selectable direction and period.
// - Counting up wraps to zero after top; counting down reloads the period at bottom.
// - After reset no clock source is selected and the counter stays off.
// - Writing a buffer sets its valid flag; update copies it and clears the flag, but capture channels copy once their channel flag is clear.
package tcb_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_COUNT = 8'h08;
    localparam logic [7:0] OFF_PER = 8'h0c;
    localparam logic [7:0] OFF_PERBUF = 8'h10;
    localparam logic [7:0] OFF_FLAGS = 8'h14;
    localparam logic [7:0] OFF_CH_BASE = 8'h20;
    localparam logic [7:0] OFF_CHBUF_BASE = 8'h30;

    // ==========================================================
    // Control fields
    localparam int CTRL_CLK_LSB = 0;
    localparam int CTRL_DIR_BIT = 4;
    localparam int CTRL_WGM_LSB = 8;
    localparam int CTRL_CAP_BIT = 12;
    localparam int CTRL_CEN_LSB = 16;

    // ==========================================================
    // Reset values
    localparam logic [15:0] RST_VAL16 = 16'h0000;
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [15:0] ALL_ONES16 = 16'hffff;

    // Clock source selection
    typedef enum logic [2:0] {
        TCB_CLK_OFF = 3'b000,
        TCB_CLK_DIV1 = 3'b001,
        TCB_CLK_PRE = 3'b010,
        TCB_CLK_EVT = 3'b011
    } tcb_clk_e;

    // Waveform generator modes
    typedef enum logic [1:0] {
        TCB_WG_NORMAL = 2'b00,
        TCB_WG_FREQ = 2'b01,
        TCB_WG_SS = 2'b10,
        TCB_WG_DS = 2'b11
    } tcb_wgm_e;

    // Event pulses toward the event fabric
    typedef struct packed {
        logic ovf;
        logic err;
        logic [3:0] cc;
    } tcb_evt_s;

    // Limit conditions
    typedef struct packed {
        logic bottom;
        logic max;
        logic top;
        logic update;
    } tcb_lim_s;

endpackage : tcb_pkg

// ===== rtl/tcb_axil.sv
// AXI4-Lite slave front end giving single word strobes
`timescale 1ns/1ps
module tcb_axil (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    output logic rd_en,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err,
    input wire logic wr_err
);
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic rbusy_q;
    logic [7:0] araddr_q;

    wire aw_take = s_awvalid & s_awready;
    wire w_take = s_wvalid & s_wready;
    wire fire_w = aw_have_q & w_have_q & ~s_bvalid;
    wire ar_take = s_arvalid & s_arready;

    // Next holding state, so that every ready leaves from a flop
    wire aw_have_d = fire_w ? 1'b0 : (aw_take | aw_have_q);
    wire w_have_d = fire_w ? 1'b0 : (w_take | w_have_q);
    wire bvalid_d = fire_w | (s_bvalid & ~s_bready);
    wire rvalid_d = rbusy_q | (s_rvalid & ~s_rready);
    assign wr_en = fire_w;
    assign wr_addr = awaddr_q;
    assign wr_data = wdata_q;
    assign wr_strb = wstrb_q;
    assign rd_en = rbusy_q;
    assign rd_addr = araddr_q;

    // Write channel capture and response
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp <= 2'b00;
            s_awready <= 1'b1;
            s_wready <= 1'b1;
        end else begin
            s_awready <= ~aw_have_d & ~bvalid_d; // Ready while no write is held
            s_wready <= ~w_have_d & ~bvalid_d;
            if (aw_take) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_awaddr;
            end
            if (w_take) begin
                w_have_q <= 1'b1;
                wdata_q <= s_wdata;
                wstrb_q <= s_wstrb;
            end
            if (fire_w) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= wr_err ? 2'b10 : 2'b00;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // Read channel
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rbusy_q <= 1'b0;
            araddr_q <= 8'h00;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= 2'b00;
            s_arready <= 1'b1;
        end else begin
            s_arready <= ~ar_take & ~rvalid_d; // Ready while no read is under way
            if (ar_take) begin
                rbusy_q <= 1'b1;
                araddr_q <= s_araddr;
            end else if (rbusy_q) begin
                rbusy_q <= 1'b0;
                s_rvalid <= 1'b1;
                s_rdata <= rd_data;
                s_rresp <= rd_err ? 2'b10 : 2'b00;
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end
endmodule : tcb_axil

// ===== tb/tcb_timer_assertions.sv
// Checker of the timer counter base ports
`timescale 1ns/1ps
module tcb_timer_assertions #(
    parameter int NUM_CH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic s_awvalid,
    input wire logic s_awready,
    input wire logic s_wvalid,
    input wire logic s_wready,
    input wire logic s_bvalid,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic s_rvalid,
    input wire tcb_pkg::tcb_evt_s evt_q,
    input wire tcb_pkg::tcb_lim_s lim_q
);
    // ==========================================================
    // Event pulses, limit conditions and bus answers
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    ovf_pulse_a: assert property (evt_q.ovf |=> !evt_q.ovf)
        else $error("overflow pulse too long");
    err_pulse_a: assert property (evt_q.err |=> !evt_q.err)
        else $error("error pulse too long");
    cc_pulse_a: assert property (|evt_q.cc |=> (evt_q.cc & $past(evt_q.cc)) == 4'h0)
        else $error("channel pulse too long");
    upd_pulse_a: assert property (lim_q.update |=> !lim_q.update)
        else $error("update pulse too long");
    bot_max_a: assert property (lim_q.bottom |-> !lim_q.max)
        else $error("bottom and maximum together");
    ovf_limit_a: assert property (evt_q.ovf |-> lim_q.top || lim_q.bottom)
        else $error("overflow away from top or bottom");
    upd_limit_a: assert property (lim_q.update |-> lim_q.top || lim_q.bottom
        || $past(lim_q.top) || $past(lim_q.bottom))
        else $error("update away from top or bottom");
    red_chan_a: assert property (NUM_CH > 2 || evt_q.cc[3:2] == 2'h0)
        else $error("missing channel produced an event");
    wr_answer_a: assert property (s_awvalid && s_awready && s_wvalid && s_wready
        |-> ##[1:2] s_bvalid)
        else $error("write answer late");
    rd_answer_a: assert property (s_arvalid && s_arready |-> ##[1:3] s_rvalid)
        else $error("read answer late");

    // Main scenarios reached
    cover property (evt_q.ovf);
    cover property (evt_q.err);
    cover property (|evt_q.cc);
    cover property (lim_q.update);
endmodule : tcb_timer_assertions

bind tcb_timer tcb_timer_assertions #(.NUM_CH(NUM_CH)) u_chk (
    .clk, .rst_n, .s_awvalid, .s_awready, .s_wvalid, .s_wready, .s_bvalid,
    .s_arvalid, .s_arready, .s_rvalid, .evt_q, .lim_q
);

// ===== tb/tcb_far_model.sv
// Far side model: prescaler ticks, counting events and capture events
`timescale 1ns/1ps
module tcb_far_model #(
    parameter int PRE_DIV = 4,
    parameter int EVT_DIV = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] capt_req,
    output logic presc_tick,
    output logic count_evt,
    output logic [3:0] capt_evt
);
    int pre_q;
    int evc_q;

    // ==========================================================
    // Free running dividers; capture requests leave one cycle late
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= 0;
            evc_q <= 0;
            presc_tick <= 1'h0;
            count_evt <= 1'h0;
            capt_evt <= 4'h0;
        end else begin
            pre_q <= (pre_q == PRE_DIV - 1) ? 0 : pre_q + 1;
            evc_q <= (evc_q == EVT_DIV - 1) ? 0 : evc_q + 1;
            presc_tick <= (pre_q == PRE_DIV - 1);
            count_evt <= (evc_q == EVT_DIV - 1);
            capt_evt <= capt_req;
        end
    end
endmodule : tcb_far_model

// ===== tb/tcb_timer_tb.sv
// Self-checking testbench of the timer counter base
`timescale 1ns/1ps
module tcb_timer_tb;
    localparam int PRE = 4;
    localparam int EVD = 3;
    localparam int PER = 9;
    localparam int CHA = 4;
    logic clk, rst_n, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready, presc_tick, count_evt;
    logic [7:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, d;
    logic [3:0] s_wstrb, capt_evt, capt_req;
    logic [1:0] s_bresp, s_rresp;
    logic [5:0] seen;
    tcb_pkg::tcb_evt_s evt_q;
    tcb_pkg::tcb_lim_s lim_q;
    int error_cnt, samples_checked, cyc, n;

    tcb_timer #(.NUM_CH(4)) uut (.clk, .rst_n, .s_awaddr, .s_awvalid, .s_awready,
        .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
        .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
        .presc_tick, .count_evt, .capt_evt, .evt_q, .lim_q);
    tcb_far_model #(.PRE_DIV(PRE), .EVT_DIV(EVD)) far (.clk, .rst_n, .capt_req,
        .presc_tick, .count_evt, .capt_evt);

    // ==========================================================
    // Clock and hang guard
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge clk);
        s_awaddr <= a;
        s_wdata <= v;
        s_awvalid <= 1'h1;
        s_wvalid <= 1'h1;
        s_bready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_awready) s_awvalid <= 1'h0;
            if (s_wready) s_wvalid <= 1'h0;
        end while (s_bvalid !== 1'h1);
        s_bready <= 1'h0;
        chk("bresp", {30'h0, er}, {30'h0, s_bresp});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
        @(posedge clk);
        s_araddr <= a;
        s_arvalid <= 1'h1;
        s_rready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_arready) s_arvalid <= 1'h0;
        end while (s_rvalid !== 1'h1);
        v = s_rdata;
        s_rready <= 1'h0;
        chk("rresp", {30'h0, er}, {30'h0, s_rresp});
    endtask : rd

    task automatic wait_ovf(output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (evt_q.ovf !== 1'h1 && c < 2000);
    endtask : wait_ovf

    task automatic capt(input int ch, output logic [5:0] s);
        s = 6'h0;
        @(posedge clk);
        capt_req[ch] <= 1'h1;
        @(posedge clk);
        capt_req[ch] <= 1'h0;
        repeat (6) begin
            @(posedge clk);
            s = s | evt_q;
        end
    endtask : capt

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        logic [7:0] ad [5] = '{8'h00, 8'h08, 8'h0c, 8'h14, 8'h04};
        logic [31:0] ex [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1};
        foreach (ad[i]) begin
            rd(ad[i], 2'h0, d);
            chk("reset value", ex[i], d);
        end
        rd(8'h40, 2'h2, d);
        chk("unmapped", 32'h0, d);
        rd(8'h2c, 2'h0, d);
        chk("channel d", 32'h0, d);
        wr(8'h08, 32'h55, 2'h0);
        repeat (10) @(posedge clk);
        rd(8'h08, 2'h0, d);
        chk("count stopped", 32'h55, d);
        $display("test reset done");
    endtask : t_reset

    task automatic t_count;
        logic [31:0] ctl [6] = '{32'h1, 32'h2, 32'h3, 32'h11, 32'h101, 32'h301};
        int gap [6] = '{PER + 1, (PER + 1) * PRE, (PER + 1) * EVD, PER + 1, CHA + 1, PER + 1};
        foreach (ctl[i]) begin
            wr(8'h00, 32'h0, 2'h0);
            wr(8'h08, 32'h0, 2'h0);
            wr(8'h0c, PER, 2'h0);
            wr(8'h20, CHA, 2'h0);
            wr(8'h00, ctl[i], 2'h0);
            wait_ovf(n);
            wait_ovf(n);
            chk("ovf gap", gap[i], n);
        end
        wr(8'h00, 32'h0, 2'h0);
        wr(8'h0c, 32'hffff, 2'h0);
        wr(8'h08, 32'hfffe, 2'h0);
        wr(8'h00, 32'h1, 2'h0);
        seen = 6'h0;
        repeat (6) begin
            @(posedge clk);
            seen[3:0] = seen[3:0] | {evt_q.cc[1], lim_q.bottom, lim_q.top, lim_q.max};
        end
        chk("limits seen", 32'hf, {28'h0, seen[3:0]});
        $display("test count done");
    endtask : t_count

    task automatic t_buffer;
        wr(8'h00, 32'h0, 2'h0);
        wr(8'h08, 32'h0, 2'h0);
        wr(8'h0c, PER, 2'h0);
        wr(8'h10, 32'h7, 2'h0);
        wr(8'h30, 32'h3, 2'h0);
        rd(8'h04, 2'h0, d);
        chk("buffer valid", 32'h23, d);
        rd(8'h0c, 2'h0, d);
        chk("period held", PER, d);
        wr(8'h00, 32'h1, 2'h0);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (lim_q.update !== 1'h1 && n < 100);
        wr(8'h00, 32'h0, 2'h0);
        rd(8'h0c, 2'h0, d);
        chk("period copied", 32'h7, d);
        rd(8'h20, 2'h0, d);
        chk("channel copied", 32'h3, d);
        rd(8'h04, 2'h0, d);
        chk("valid cleared", 32'h0, d & 32'h3e);
        $display("test buffer done");
    endtask : t_buffer

    task automatic t_capture;
        wr(8'h00, 32'h0, 2'h0);
        wr(8'h08, 32'h1234, 2'h0);
        wr(8'h14, 32'h3f, 2'h0);
        wr(8'h00, 32'h000f_1000, 2'h0);
        capt(1, seen);
        chk("capture event", 32'h2, {26'h0, seen});
        rd(8'h24, 2'h0, d);
        chk("captured value", 32'h1234, d);
        capt(1, seen);
        rd(8'h04, 2'h0, d);
        chk("capture buffered", 32'h4, d & 32'h1e);
        capt(1, seen);
        chk("error event", 32'h1, {31'h0, seen[4]});
        rd(8'h14, 2'h0, d);
        chk("channel flag", 32'h2, d & 32'h2);
        $display("test capture done");
    endtask : t_capture

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // ==========================================================
    // Main sequence
    initial begin
        rst_n = 1'h0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h0;
        s_awaddr = 8'h0;
        s_araddr = 8'h0;
        s_wdata = 32'h0;
        s_wstrb = 4'hf;
        capt_req = 4'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        t_reset();
        t_count();
        t_buffer();
        t_capture();
        end_of_test();
    end
endmodule : tcb_timer_tb
